// ==== logic/siwc_top.sv ====
/*
  Interrupt and wake-up control register with its gating logic.
  Holds the 16-bit control register, the chip mode field, wake input edge
  detection and the LIN channel state outputs, reached over Avalon-MM.
  Assumes one 25 MHz clock, a synchronous active-low reset, and that all
  analog event inputs (pins) are asynchronous and get synchronised here.
*/
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
module siwc_top
  import siwc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        wake_in_a,
  input  wire logic        wake_in_b,
  input  wire logic        main_supply_low,
  input  wire logic        can_supply_low,
  input  wire logic        lin_a_bus_wake,
  input  wire logic        lin_b_bus_wake,
  output logic [1:0]       lin_a_state,
  output logic [1:0]       lin_b_state,
  output logic             lin_a_receive_out,
  output logic             lin_b_receive_out,
  output logic             main_low_irq,
  output logic             can_low_irq,
  output logic             wake_a_irq,
  output logic             wake_b_irq,
  output logic             lin_a_wake_irq,
  output logic             lin_b_wake_irq
);

  siwc_state_t st;
  siwc_state_t next_st;
  logic [15:0] ctrl_word;
  logic        normal_mode;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        a_rise;
  logic        a_fall;
  logic        b_rise;
  logic        b_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Read view of the control register; the id code is wired, never stored.
  assign ctrl_word = {SIWC_ID_CODE, st.write_lock,
                      st.main_supply_low_irq_enable, st.can_supply_low_irq_enable,
                      st.lin_a_standby_ctrl, st.lin_b_standby_ctrl,
                      st.wake_in_a_edge_select, st.wake_in_b_edge_select, 4'h0};

  // Normal modes are the two codes with the upper bit set.
  assign normal_mode = st.chip_mode_field[1];

  // Edges seen between the second and third synchroniser stages.
  assign a_rise = st.wake_a_sync[1] & ~st.wake_a_sync[2];
  assign a_fall = ~st.wake_a_sync[1] & st.wake_a_sync[2];
  assign b_rise = st.wake_b_sync[1] & ~st.wake_b_sync[2];
  assign b_fall = ~st.wake_b_sync[1] & st.wake_b_sync[2];

  // A write lands only in the answer cycle, so it takes effect exactly once.
  assign wr_ctrl = (st.bus == SIWC_ANSWER) && write && (address == SIWC_ADDR_CTRL);
  assign wr_mode = (st.bus == SIWC_ANSWER) && write && (address == SIWC_ADDR_MODE);

  ////////////////////////////////////////////////////////////////////////////
  // Waitrequest drops for one cycle in the answer state; one wait per access.
  assign waitrequest = (read || write) && (st.bus != SIWC_ANSWER);
  assign readdata    = st.readdata;

  // Outputs from the state flops; the receive outputs are the inverted wake flags.
  assign main_low_irq      = st.main_low_irq;
  assign can_low_irq       = st.can_low_irq;
  assign wake_a_irq        = st.wake_a_irq;
  assign wake_b_irq        = st.wake_b_irq;
  assign lin_a_wake_irq    = st.lin_a_wake_irq;
  assign lin_b_wake_irq    = st.lin_b_wake_irq;
  assign lin_a_receive_out = ~st.lin_a_wake_flag;
  assign lin_b_receive_out = ~st.lin_b_wake_flag;

  // Channel state decoding from standby control and chip mode.
  always_comb begin
    if (st.lin_a_standby_ctrl) begin
      lin_a_state = SIWC_LIN_LOWPOWER;
    end else if (normal_mode) begin
      lin_a_state = SIWC_LIN_ACTIVE;
    end else begin
      lin_a_state = SIWC_LIN_OFF;
    end
    if (st.lin_b_standby_ctrl) begin
      lin_b_state = SIWC_LIN_LOWPOWER;
    end else if (normal_mode) begin
      lin_b_state = SIWC_LIN_ACTIVE;
    end else begin
      lin_b_state = SIWC_LIN_OFF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block.
  always_comb begin
    next_st = st;
    // Two-flop synchronisers; third stage of the wake inputs feeds edge logic.
    next_st.wake_a_sync     = {st.wake_a_sync[1:0], wake_in_a};
    next_st.wake_b_sync     = {st.wake_b_sync[1:0], wake_in_b};
    next_st.main_low_sync   = {st.main_low_sync[0], main_supply_low};
    next_st.can_low_sync    = {st.can_low_sync[0], can_supply_low};
    next_st.lin_a_wake_sync = {st.lin_a_wake_sync[0], lin_a_bus_wake};
    next_st.lin_b_wake_sync = {st.lin_b_wake_sync[0], lin_b_bus_wake};

    // Undervoltage requests are level requests, gated by their enables.
    next_st.main_low_irq = st.main_low_sync[1] & st.main_supply_low_irq_enable;
    next_st.can_low_irq  = st.can_low_sync[1] & st.can_supply_low_irq_enable;

    // Wake input pulses by edge selection.
    case (st.wake_in_a_edge_select)
      SIWC_EDGE_RISE: next_st.wake_a_irq = a_rise;
      SIWC_EDGE_FALL: next_st.wake_a_irq = a_fall;
      SIWC_EDGE_BOTH: next_st.wake_a_irq = a_rise | a_fall;
      default:        next_st.wake_a_irq = 1'b0;
    endcase
    case (st.wake_in_b_edge_select)
      SIWC_EDGE_RISE: next_st.wake_b_irq = b_rise;
      SIWC_EDGE_FALL: next_st.wake_b_irq = b_fall;
      SIWC_EDGE_BOTH: next_st.wake_b_irq = b_rise | b_fall;
      default:        next_st.wake_b_irq = 1'b0;
    endcase

    // LIN wake flags: captured only in low power, cleared when active.
    // Off mode leaves the flag alone but neither sets it nor requests.
    if (st.lin_a_standby_ctrl) begin
      next_st.lin_a_wake_flag = st.lin_a_wake_flag | st.lin_a_wake_sync[1];
    end else if (normal_mode) begin
      next_st.lin_a_wake_flag = 1'b0;
    end
    if (st.lin_b_standby_ctrl) begin
      next_st.lin_b_wake_flag = st.lin_b_wake_flag | st.lin_b_wake_sync[1];
    end else if (normal_mode) begin
      next_st.lin_b_wake_flag = 1'b0;
    end
    next_st.lin_a_wake_irq = st.lin_a_standby_ctrl & st.lin_a_wake_sync[1];
    next_st.lin_b_wake_irq = st.lin_b_standby_ctrl & st.lin_b_wake_sync[1];

    // Bus slave: one wait cycle, then answer.
    case (st.bus)
      SIWC_IDLE: begin
        if (read || write) begin
          next_st.bus = SIWC_ANSWER;
          if (address == SIWC_ADDR_CTRL) begin
            next_st.readdata = {16'h0000, ctrl_word};
          end else if (address == SIWC_ADDR_MODE) begin
            next_st.readdata = {30'h0000000, st.chip_mode_field};
          end else begin
            next_st.readdata = 32'h00000000;                       // Unmapped reads zero.
          end
        end
      end
      SIWC_ANSWER: begin
        next_st.bus = SIWC_IDLE;
      end
      default: next_st.bus = SIWC_IDLE;
    endcase

    // Control writes are ignored while locked, including the lock bit itself.
    if (wr_ctrl && !st.write_lock) begin
      if (byteenable[1]) begin
        next_st.write_lock                 = writedata[SIWC_LOCK_BIT];
        next_st.main_supply_low_irq_enable = writedata[SIWC_MAIN_IE_BIT];
        next_st.can_supply_low_irq_enable  = writedata[SIWC_CAN_IE_BIT];
        next_st.lin_a_standby_ctrl         = writedata[SIWC_LIN_A_BIT];
        next_st.lin_b_standby_ctrl         = writedata[SIWC_LIN_B_BIT];
      end
      if (byteenable[0]) begin
        next_st.wake_in_a_edge_select = writedata[SIWC_WAKE_A_HI:SIWC_WAKE_A_LO];
        next_st.wake_in_b_edge_select = writedata[SIWC_WAKE_B_HI:SIWC_WAKE_B_LO];
      end
    end
    if (wr_mode && byteenable[0]) begin
      next_st.chip_mode_field = writedata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; synchronous reset clears every writable field.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
      st.chip_mode_field <= SIWC_MODE_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_locked_write;
    st.write_lock && wr_ctrl;
  endsequence

  a_id_bits_fixed: assert property (ctrl_word[15:13] == 3'h2)
    else $error("Register id code changed.");
  a_lock_holds_ctrl: assert property (s_locked_write |=> $stable(ctrl_word))
    else $error("Locked register changed on write.");
  a_main_irq_gate: assert property (!st.main_supply_low_irq_enable |=> !main_low_irq)
    else $error("Main undervoltage request while disabled.");
  a_can_irq_gate: assert property (!st.can_supply_low_irq_enable |=> !can_low_irq)
    else $error("CAN undervoltage request while disabled.");

  // An enabled undervoltage request must reach its output one cycle later.
  a_main_irq_pass: assert property (st.main_supply_low_irq_enable && st.main_low_sync[1] |=>
                                    main_low_irq)
    else $error("Main undervoltage request lost while enabled.");
  a_can_irq_pass: assert property (st.can_supply_low_irq_enable && st.can_low_sync[1] |=>
                                   can_low_irq)
    else $error("CAN undervoltage request lost while enabled.");

  // Channel A: active in normal modes, off in standby or sleep, low power when set.
  a_lin_a_active: assert property (!st.lin_a_standby_ctrl && normal_mode |=>
                                   lin_a_receive_out)
    else $error("LIN A wake flag not cleared in normal mode.");
  a_lin_a_normal: assert property (!st.lin_a_standby_ctrl && normal_mode |->
                                   lin_a_state == SIWC_LIN_ACTIVE)
    else $error("LIN A not active in normal mode.");
  a_lin_a_off: assert property (!st.lin_a_standby_ctrl && !normal_mode |->
                                lin_a_state == SIWC_LIN_OFF ##1 !lin_a_wake_irq)
    else $error("LIN A not off or requesting in standby.");
  a_lin_a_low: assert property (st.lin_a_standby_ctrl && st.lin_a_wake_sync[1] |=>
                                lin_a_wake_irq && !lin_a_receive_out)
    else $error("LIN A wake missed in low power.");
  a_lin_a_lowpower: assert property (st.lin_a_standby_ctrl |->
                                     lin_a_state == SIWC_LIN_LOWPOWER)
    else $error("LIN A not in low power.");

  // Channel B: the same three states under its own standby control.
  a_lin_b_active: assert property (!st.lin_b_standby_ctrl && normal_mode |=>
                                   lin_b_receive_out)
    else $error("LIN B wake flag not cleared in normal mode.");
  a_lin_b_normal: assert property (!st.lin_b_standby_ctrl && normal_mode |->
                                   lin_b_state == SIWC_LIN_ACTIVE)
    else $error("LIN B not active in normal mode.");
  a_lin_b_off: assert property (!st.lin_b_standby_ctrl && !normal_mode |->
                                lin_b_state == SIWC_LIN_OFF ##1 !lin_b_wake_irq)
    else $error("LIN B not off or requesting in standby.");
  a_lin_b_low: assert property (st.lin_b_standby_ctrl |-> lin_b_state == SIWC_LIN_LOWPOWER)
    else $error("LIN B not in low power.");
  a_lin_b_wake: assert property (st.lin_b_standby_ctrl && st.lin_b_wake_sync[1] |=>
                                 lin_b_wake_irq && !lin_b_receive_out)
    else $error("LIN B wake missed in low power.");

  // Wake inputs: each selected edge gives a pulse, a cleared field gives none.
  a_wake_a_rise: assert property (st.wake_in_a_edge_select == SIWC_EDGE_RISE && a_rise
                                  |=> wake_a_irq)
    else $error("Wake A rising edge missed.");
  a_wake_a_fall: assert property (st.wake_in_a_edge_select == SIWC_EDGE_FALL && a_fall
                                  |=> wake_a_irq)
    else $error("Wake A falling edge missed.");
  a_wake_a_off: assert property (st.wake_in_a_edge_select == SIWC_EDGE_OFF |=> !wake_a_irq)
    else $error("Wake A request while disabled.");
  a_wake_b_rise: assert property (st.wake_in_b_edge_select == SIWC_EDGE_RISE && b_rise
                                  |=> wake_b_irq)
    else $error("Wake B rising edge missed.");
  a_wake_b_both: assert property (st.wake_in_b_edge_select == SIWC_EDGE_BOTH && b_fall
                                  |=> wake_b_irq)
    else $error("Wake B falling edge missed in both-edge mode.");
  a_wake_b_off: assert property (st.wake_in_b_edge_select == SIWC_EDGE_OFF |=> !wake_b_irq)
    else $error("Wake B request while disabled.");
  a_reset_clear: assert property ($rose(rstn) |-> ctrl_word[12:4] == 9'h000)
    else $error("Fields not zero after reset.");

endmodule

// ==== logic/siwc_pkg.sv ====
/*
  Package for the interrupt and wake-up control block: register offset,
  field positions, reset values, mode and channel-state encodings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package siwc_pkg;

  // Register map, byte address on the Avalon-MM slave (index 2, four bytes a word).
  localparam logic [7:0]  SIWC_REG_IDX         = 8'h02;
  localparam logic [7:0]  SIWC_ADDR_CTRL       = 8'h08;
  localparam logic [7:0]  SIWC_ADDR_MODE       = 8'h0C;

  // Field positions in the control register.
  localparam int          SIWC_ID_HI           = 15;
  localparam int          SIWC_ID_LO           = 13;
  localparam int          SIWC_LOCK_BIT        = 12;
  localparam int          SIWC_MAIN_IE_BIT     = 11;
  localparam int          SIWC_CAN_IE_BIT      = 10;
  localparam int          SIWC_LIN_A_BIT       = 9;
  localparam int          SIWC_LIN_B_BIT       = 8;
  localparam int          SIWC_WAKE_A_HI       = 7;
  localparam int          SIWC_WAKE_A_LO       = 6;
  localparam int          SIWC_WAKE_B_HI       = 5;
  localparam int          SIWC_WAKE_B_LO       = 4;

  // Fixed register address code and reset values.
  localparam logic [2:0]  SIWC_ID_CODE         = 3'h2;
  localparam logic [12:4] SIWC_CTRL_RESET      = 9'h000;
  localparam logic [1:0]  SIWC_MODE_RESET      = 2'h0;

  // Wake input edge selections.
  localparam logic [1:0]  SIWC_EDGE_OFF        = 2'h0;
  localparam logic [1:0]  SIWC_EDGE_RISE       = 2'h1;
  localparam logic [1:0]  SIWC_EDGE_FALL       = 2'h2;
  localparam logic [1:0]  SIWC_EDGE_BOTH       = 2'h3;

  // Chip operating mode codes.
  localparam logic [1:0]  SIWC_MODE_STANDBY    = 2'h0;
  localparam logic [1:0]  SIWC_MODE_SLEEP      = 2'h1;
  localparam logic [1:0]  SIWC_MODE_NORM_OFF   = 2'h2;
  localparam logic [1:0]  SIWC_MODE_NORM_ON    = 2'h3;

  // LIN channel state outputs.
  localparam logic [1:0]  SIWC_LIN_OFF         = 2'h0;
  localparam logic [1:0]  SIWC_LIN_ACTIVE      = 2'h1;
  localparam logic [1:0]  SIWC_LIN_LOWPOWER    = 2'h2;

  // Bus state machine.
  typedef enum logic [1:0] {SIWC_IDLE, SIWC_ANSWER} siwc_bus_t;

  // Whole state of the block.
  typedef struct packed {
    siwc_bus_t   bus;
    logic        write_lock;
    logic        main_supply_low_irq_enable;
    logic        can_supply_low_irq_enable;
    logic        lin_a_standby_ctrl;
    logic        lin_b_standby_ctrl;
    logic [1:0]  wake_in_a_edge_select;
    logic [1:0]  wake_in_b_edge_select;
    logic [1:0]  chip_mode_field;
    logic [31:0] readdata;
    logic [2:0]  wake_a_sync;
    logic [2:0]  wake_b_sync;
    logic [1:0]  main_low_sync;
    logic [1:0]  can_low_sync;
    logic [1:0]  lin_a_wake_sync;
    logic [1:0]  lin_b_wake_sync;
    logic        lin_a_wake_flag;
    logic        lin_b_wake_flag;
    logic        main_low_irq;
    logic        can_low_irq;
    logic        wake_a_irq;
    logic        wake_b_irq;
    logic        lin_a_wake_irq;
    logic        lin_b_wake_irq;
  } siwc_state_t;

endpackage

// ==== dv/siwc_host.sv ====
/*
  Host model: an Avalon-MM master that issues one register access at a time.
  Assumes the slave raises waitrequest while busy and that clk is the slave's clock.
*/
`timescale 1ns/100ps
module siwc_host (
  input  wire logic        clk,
  output logic [7:0]       address,
  output logic             read,
  output logic             write,
  output logic [31:0]      writedata,
  output logic [3:0]       byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  // The bus is idle from time zero so reset sees no request.
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One access: raise after an edge and hold until waitrequest is low at an edge.
  // Waitrequest and read data are taken at the rising edge itself, before that
  // edge's own updates land, so the master never guesses the slave's latency.
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

// ==== dv/siwc_top_test.sv ====
/*
  Self-checking bench for the interrupt and wake-up control block.
  Assumes the host model file is compiled first; event pins are driven directly.
*/
`timescale 1ns/100ps
module siwc_top_test;
  import siwc_pkg::*;
  logic        clk, rstn, read, write, waitrequest;
  logic [7:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic        wake_in_a, wake_in_b, main_supply_low, can_supply_low;
  logic        lin_a_bus_wake, lin_b_bus_wake, lin_a_receive_out, lin_b_receive_out;
  logic [1:0]  lin_a_state, lin_b_state, code;
  logic        main_low_irq, can_low_irq, wake_a_irq, wake_b_irq;
  logic        lin_a_wake_irq, lin_b_wake_irq;
  int          err_count, cmp_count, cyc, pulses_a, pulses_b, base_a, base_b;

  siwc_host HOST (.clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest));
  siwc_top DUT (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .wake_in_a(wake_in_a), .wake_in_b(wake_in_b),
    .main_supply_low(main_supply_low), .can_supply_low(can_supply_low),
    .lin_a_bus_wake(lin_a_bus_wake), .lin_b_bus_wake(lin_b_bus_wake),
    .lin_a_state(lin_a_state), .lin_b_state(lin_b_state),
    .lin_a_receive_out(lin_a_receive_out), .lin_b_receive_out(lin_b_receive_out),
    .main_low_irq(main_low_irq), .can_low_irq(can_low_irq), .wake_a_irq(wake_a_irq),
    .wake_b_irq(wake_b_irq), .lin_a_wake_irq(lin_a_wake_irq),
    .lin_b_wake_irq(lin_b_wake_irq));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 40 ns; cycle counter cuts a hang short.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end
  // Wake pulses are counted mid-cycle, so a stuck or doubled pulse shows up.
  always @(negedge clk) begin
    if (wake_a_irq === 1'b1) pulses_a++;
    if (wake_b_irq === 1'b1) pulses_b++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    HOST.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    HOST.access(1'b0, a, 32'h0000_0000, q);
    chk(n, e, q);
  endtask
  // Six cycles cover the two-flop sync plus the registered outputs.
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the lock test comes last because only reset undoes it.
  initial begin
    {rstn, wake_in_a, wake_in_b, main_supply_low, can_supply_low} = 5'h00;
    {lin_a_bus_wake, lin_b_bus_wake} = 2'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(SIWC_ADDR_CTRL, 32'h0000_4000, "ctrl_reset");
    rd(SIWC_ADDR_MODE, 32'h0000_0000, "mode_reset");
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0000, "unmapped");
    wr(SIWC_ADDR_CTRL, 32'hFFFF_EFFF);
    rd(SIWC_ADDR_CTRL, 32'h0000_4FF0, "ctrl_write");
    main_supply_low <= 1'b1;
    can_supply_low <= 1'b1;
    wr(SIWC_ADDR_CTRL, 32'h0000_0800);
    settle();
    chk("main_low_irq", 32'h1, 32'(main_low_irq));
    chk("can_low_irq", 32'h0, 32'(can_low_irq));
    wr(SIWC_ADDR_CTRL, 32'h0000_0400);
    settle();
    chk("main_low_irq", 32'h0, 32'(main_low_irq));
    chk("can_low_irq", 32'h1, 32'(can_low_irq));
    // Every mode with one channel low power and the other under mode control.
    for (int m = 0; m < 4; m++) begin
      wr(SIWC_ADDR_MODE, 32'(m));
      wr(SIWC_ADDR_CTRL, 32'h0000_0200);
      settle();
      chk("lin_a_state", 32'(SIWC_LIN_LOWPOWER), 32'(lin_a_state));
      chk("lin_b_state", 32'(m > 1 ? SIWC_LIN_ACTIVE : SIWC_LIN_OFF), 32'(lin_b_state));
      wr(SIWC_ADDR_CTRL, 32'h0000_0100);
      settle();
      chk("lin_a_state", 32'(m > 1 ? SIWC_LIN_ACTIVE : SIWC_LIN_OFF), 32'(lin_a_state));
      chk("lin_b_state", 32'(SIWC_LIN_LOWPOWER), 32'(lin_b_state));
    end
    // Bus wake in low power, then off in standby, then cleared in normal mode.
    wr(SIWC_ADDR_MODE, 32'h0000_0000);
    wr(SIWC_ADDR_CTRL, 32'h0000_0300);
    lin_a_bus_wake <= 1'b1;
    lin_b_bus_wake <= 1'b1;
    settle();
    chk("lin_wake_irqs", 32'h3, 32'({lin_a_wake_irq, lin_b_wake_irq}));
    chk("receive_outs", 32'h0, 32'({lin_a_receive_out, lin_b_receive_out}));
    wr(SIWC_ADDR_CTRL, 32'h0000_0000);
    settle();
    chk("lin_wake_irqs", 32'h0, 32'({lin_a_wake_irq, lin_b_wake_irq}));
    wr(SIWC_ADDR_MODE, 32'h0000_0003);
    settle();
    chk("receive_outs", 32'h3, 32'({lin_a_receive_out, lin_b_receive_out}));
    // Each edge code on both wake inputs: one pulse per selected edge.
    for (int c = 0; c < 4; c++) begin
      code = c[1:0];
      wr(SIWC_ADDR_CTRL, 32'({code, code, 4'h0}));
      settle();
      // The counters have one driver; each phase is measured from a snapshot.
      base_a = pulses_a;
      base_b = pulses_b;
      wake_in_a <= 1'b1;
      wake_in_b <= 1'b1;
      settle();
      chk("rise_a", 32'(code[0]), 32'(pulses_a - base_a));
      chk("rise_b", 32'(code[0]), 32'(pulses_b - base_b));
      base_a = pulses_a;
      base_b = pulses_b;
      wake_in_a <= 1'b0;
      wake_in_b <= 1'b0;
      settle();
      chk("fall_a", 32'(code[1]), 32'(pulses_a - base_a));
      chk("fall_b", 32'(code[1]), 32'(pulses_b - base_b));
    end
    wr(SIWC_ADDR_CTRL, 32'h0000_1C00);
    wr(SIWC_ADDR_CTRL, 32'h0000_0000);
    rd(SIWC_ADDR_CTRL, 32'h0000_5C00, "ctrl_locked");
    // A second reset in mid-run is the only way out of the lock.
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(SIWC_ADDR_CTRL, 32'h0000_4000, "ctrl_after_reset");
    close_out();
  end
endmodule
